// ### shared/pwmc_pkg.sv
package pwmc_pkg;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_CS01 = 8'hd5;
    localparam logic [7:0] ADDR_CS23 = 8'he5;
    localparam logic [7:0] ADDR_CON01 = 8'hdd;
    localparam logic [7:0] ADDR_CON23 = 8'hed;
    // Index 0..3 is the channel number
    localparam logic [3:0][7:0] ADDR_FG = {8'he7, 8'he6, 8'hd7, 8'hd6};
    localparam logic [3:0][7:0] ADDR_VAL = {8'hef, 8'hee, 8'hdf, 8'hde};

    // ----------------------------------------
    // Field positions inside a channel nibble
    // ----------------------------------------
    // Even channel uses the high nibble, odd channel the low nibble
    localparam int HI_NIB_LSB = 4;
    localparam int CS_EN = 0;
    localparam int CS_SEL_LSB = 1;
    localparam int CON_TC = 0;
    localparam int CON_OE = 1;
    localparam int CON_DC = 2;
    localparam int CON_FLAG = 3;

    // ----------------------------------------
    // Reset values and constants
    // ----------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] TMR_ZERO = 8'h00;
    localparam logic [7:0] TMR_STEP = 8'h01;
    localparam logic [5:0] PRE_STEP = 6'h01;
    localparam logic [5:0] PRE_MASK4 = 6'h03;
    localparam logic [5:0] PRE_MASK16 = 6'h0f;
    localparam logic [5:0] PRE_MASK64 = 6'h3f;

    // Clock source select codes, bit 2 set picks the pin
    localparam logic [1:0] SEL_DIV1 = 2'h0;
    localparam logic [1:0] SEL_DIV4 = 2'h1;
    localparam logic [1:0] SEL_DIV16 = 2'h2;
    localparam logic [1:0] SEL_DIV64 = 2'h3;
    localparam int SEL_EXT_BIT = 2;

endpackage

// ### src/pwmc_chan.sv
`timescale 1ns/1ns

module pwmc_chan (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Clock source and divider control
    input wire logic i_src_tick,
    input wire logic i_en,
    input wire logic [7:0] i_div,
    // Value register writes
    input wire logic i_tmr_wr,
    input wire logic i_cmp_wr,
    input wire logic [7:0] i_wdata,
    // Channel state
    output logic [7:0] o_tmr,
    output logic [7:0] o_pend,
    output logic o_roll,
    output logic o_out
);

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] tmr;
        logic [7:0] cmp_act;
        logic [7:0] pend;
        logic out;
    } pwmc_chan_st_t;

    pwmc_chan_st_t q;
    pwmc_chan_st_t d;
    logic tick;
    logic adv;
    logic match;
    logic [7:0] nxt;

    // ----------------------------------------
    // Divider, timer and comparator
    // ----------------------------------------
    always_comb begin
        d = q;
        nxt = q.tmr + pwmc_pkg::TMR_STEP;
        // Divider count is internal only, no path to software
        tick = i_en && i_src_tick && (q.cnt == pwmc_pkg::TMR_ZERO);
        adv = tick && !i_tmr_wr;
        match = adv && (nxt == q.cmp_act);
        if (!i_en) begin
            d.cnt = i_div;
        end else if (i_src_tick) begin
            // New divider only seen at reload
            d.cnt = (q.cnt == pwmc_pkg::TMR_ZERO) ? i_div : q.cnt - pwmc_pkg::TMR_STEP;
        end
        if (i_tmr_wr) begin
            d.tmr = i_wdata;
        end else if (tick) begin
            d.tmr = nxt;
        end
        if (i_cmp_wr) begin
            d.pend = i_wdata;
        end
        // Clear beats set, so compare 00h never glitches high
        if (match) begin
            d.out = 1'b0;
            d.cmp_act = q.pend;
        end else if (adv && nxt == pwmc_pkg::TMR_ZERO) begin
            d.out = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_tmr = q.tmr;
    assign o_pend = q.pend;
    assign o_out = q.out;
    assign o_roll = adv && (nxt == pwmc_pkg::TMR_ZERO);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_div_reload: assert property (tick |=> q.cnt == $past(i_div))
        else $error("divider did not reload");
    a_div_count: assert property (i_en && i_src_tick && q.cnt != 8'h00 |=> q.cnt == $past(q.cnt) - 8'h01)
        else $error("divider did not count down");
    a_div_hold: assert property (!i_en |=> q.cnt == $past(i_div) && !$past(tick))
        else $error("disabled divider moved");
    a_tmr_load: assert property (i_tmr_wr |=> q.tmr == $past(i_wdata))
        else $error("timer write lost");
    a_cmp_at_match: assert property (!$stable(q.cmp_act) |-> $past(match))
        else $error("compare changed off match");
    a_pend_read: assert property (i_cmp_wr |=> q.pend == $past(i_wdata))
        else $error("pending compare not kept");
    a_zero_low: assert property (q.cmp_act == 8'h00 |-> !q.out)
        else $error("compare 00h drove high");
    a_ff_high: assert property (adv && nxt == 8'h00 && q.cmp_act != 8'h00 |=> q.out)
        else $error("output not set at zero");

    c_match_load: cover property (match && q.pend != q.cmp_act);
    c_roll: cover property (o_roll);

endmodule

// ### src/pwmc_top.sv
`timescale 1ns/1ns

// Notes on behaviour
// - Select bit steers value access timer/compare
// - Channel clock is source over divider plus one
// - Divider value reloads an 8-bit down-timer
// - Divider count never visible to software
// - New divider correct after one reload
// - All twelve registers 8-bit, reset to zero
// - Compare write pending until previous match
// - Timer access reads live timer count
// - Timer access write loads the timer
// - Source select: 1, 4, 16, 64, pin
// - Set at zero, clear at match
// - Rollover sets flag; software clears it
// - Override forces high; pin needs enable
module pwmc_top (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // Special function register bus
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic [7:0] I_SFR_WDATA,
    output logic [7:0] O_SFR_RDATA,
    output logic O_SFR_HIT,
    // External clock pins
    input wire logic I_EXT_CLOCK_PIN_EVEN,
    input wire logic I_EXT_CLOCK_PIN_ODD,
    // Channel pins
    output logic [3:0] O_PWM,
    output logic [3:0] O_PWM_OE
);

    typedef struct packed {
        logic [1:0][7:0] cs;
        logic [1:0][7:0] con;
        logic [3:0][7:0] fg;
        logic [5:0] pre;
        logic [1:0] ext_s1;
        logic [1:0] ext_s2;
        logic [1:0] ext_s3;
        logic [7:0] rdata;
        logic hit;
        logic [3:0] pin;
        logic [3:0] oe;
    } pwmc_top_st_t;

    pwmc_top_st_t q;
    pwmc_top_st_t d;
    logic rst_s1;
    logic rst_n;
    logic [1:0] ext_edge;
    logic [3:0] src_tick;
    logic [3:0] en_w;
    logic [3:0] tc_w;
    logic [3:0] oe_w;
    logic [3:0] dc_w;
    logic [3:0][2:0] sel_w;
    logic [3:0] tmr_wr;
    logic [3:0] cmp_wr;
    logic [3:0][7:0] tmr;
    logic [3:0][7:0] pend;
    logic [3:0] roll;
    logic [3:0] out;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic int nib_lsb(input int n);
        return (n % 2 == 0) ? pwmc_pkg::HI_NIB_LSB : 0;
    endfunction

    function automatic logic [3:0] nib(input logic [7:0] r, input int n);
        return (n % 2 == 0) ? r[7:4] : r[3:0];
    endfunction

    function automatic logic pick_src(input logic [2:0] sel, input logic [5:0] pre, input logic ext);
        logic res;
        res = 1'b0;
        if (sel[pwmc_pkg::SEL_EXT_BIT]) begin
            res = ext;
        end else begin
            unique case (sel[1:0])
                pwmc_pkg::SEL_DIV1: res = 1'b1;
                pwmc_pkg::SEL_DIV4: res = (pre & pwmc_pkg::PRE_MASK4) == pwmc_pkg::PRE_MASK4;
                pwmc_pkg::SEL_DIV16: res = (pre & pwmc_pkg::PRE_MASK16) == pwmc_pkg::PRE_MASK16;
                pwmc_pkg::SEL_DIV64: res = pre == pwmc_pkg::PRE_MASK64;
            endcase
        end
        return res;
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ----------------------------------------
    // Pin clock edges
    // ----------------------------------------
    // Falling edge counts, as on ordinary timer pins
    assign ext_edge = q.ext_s3 & ~q.ext_s2;

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    for (genvar n = 0; n < 4; n++) begin : g_chan
        logic [3:0] cs_n;
        logic [3:0] con_n;
        assign cs_n = nib(q.cs[n / 2], n);
        assign con_n = nib(q.con[n / 2], n);
        assign en_w[n] = cs_n[pwmc_pkg::CS_EN];
        assign sel_w[n] = cs_n[pwmc_pkg::CS_SEL_LSB +: 3];
        assign tc_w[n] = con_n[pwmc_pkg::CON_TC];
        assign oe_w[n] = con_n[pwmc_pkg::CON_OE];
        assign dc_w[n] = con_n[pwmc_pkg::CON_DC];
        // Even channels take the even pin, odd ones the odd pin
        assign src_tick[n] = pick_src(sel_w[n], q.pre, ext_edge[n % 2]);
        assign tmr_wr[n] = I_SFR_WR && I_SFR_ADDR == pwmc_pkg::ADDR_VAL[n] && tc_w[n];
        assign cmp_wr[n] = I_SFR_WR && I_SFR_ADDR == pwmc_pkg::ADDR_VAL[n] && !tc_w[n];

        pwmc_chan u_chan (
            .i_clk(I_CLOCK),
            .i_rst_n(rst_n),
            .i_src_tick(src_tick[n]),
            .i_en(en_w[n]),
            .i_div(q.fg[n]),
            .i_tmr_wr(tmr_wr[n]),
            .i_cmp_wr(cmp_wr[n]),
            .i_wdata(I_SFR_WDATA),
            .o_tmr(tmr[n]),
            .o_pend(pend[n]),
            .o_roll(roll[n]),
            .o_out(out[n])
        );
    end

    // ----------------------------------------
    // Registers, prescaler and pins
    // ----------------------------------------
    always_comb begin
        d = q;
        // Prescaler runs free, taps shared by all channels
        d.pre = q.pre + pwmc_pkg::PRE_STEP;
        d.ext_s1 = {I_EXT_CLOCK_PIN_ODD, I_EXT_CLOCK_PIN_EVEN};
        d.ext_s2 = q.ext_s1;
        d.ext_s3 = q.ext_s2;
        d.hit = 1'b0;
        if (I_SFR_WR) begin
            case (I_SFR_ADDR)
                pwmc_pkg::ADDR_CS01: d.cs[0] = I_SFR_WDATA;
                pwmc_pkg::ADDR_CS23: d.cs[1] = I_SFR_WDATA;
                pwmc_pkg::ADDR_CON01: d.con[0] = I_SFR_WDATA;
                pwmc_pkg::ADDR_CON23: d.con[1] = I_SFR_WDATA;
                default: ;
            endcase
            for (int n = 0; n < 4; n++) begin
                if (I_SFR_ADDR == pwmc_pkg::ADDR_FG[n]) begin
                    d.fg[n] = I_SFR_WDATA;
                end
            end
        end
        // Rollover after the write, so a set in the clearing cycle survives
        for (int n = 0; n < 4; n++) begin
            if (roll[n]) begin
                d.con[n / 2][nib_lsb(n) + pwmc_pkg::CON_FLAG] = 1'b1;
            end
            d.pin[n] = oe_w[n] && (dc_w[n] || out[n]);
            d.oe[n] = oe_w[n];
        end
        if (I_SFR_RD) begin
            d.hit = 1'b1;
            d.rdata = pwmc_pkg::REG_RST;
            case (I_SFR_ADDR)
                pwmc_pkg::ADDR_CS01: d.rdata = q.cs[0];
                pwmc_pkg::ADDR_CS23: d.rdata = q.cs[1];
                pwmc_pkg::ADDR_CON01: d.rdata = q.con[0];
                pwmc_pkg::ADDR_CON23: d.rdata = q.con[1];
                default: d.hit = 1'b0;
            endcase
            for (int n = 0; n < 4; n++) begin
                if (I_SFR_ADDR == pwmc_pkg::ADDR_FG[n]) begin
                    d.hit = 1'b1;
                    d.rdata = q.fg[n];
                end
                if (I_SFR_ADDR == pwmc_pkg::ADDR_VAL[n]) begin
                    d.hit = 1'b1;
                    d.rdata = tc_w[n] ? tmr[n] : pend[n];
                end
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign O_SFR_RDATA = q.rdata;
    assign O_SFR_HIT = q.hit;
    assign O_PWM = q.pin;
    assign O_PWM_OE = q.oe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!rst_n);

    a_regs_reset: assert property ($rose(rst_n) |-> q.fg == '0 && q.cs == '0 && q.con == '0)
        else $error("registers not cleared by reset");

    for (genvar n = 0; n < 4; n++) begin : g_chk
        a_read_timer: assert property (
            I_SFR_RD && I_SFR_ADDR == pwmc_pkg::ADDR_VAL[n] && tc_w[n]
            |=> O_SFR_HIT && O_SFR_RDATA == $past(tmr[n]))
            else $error("timer read wrong");
        a_read_compare: assert property (
            I_SFR_RD && I_SFR_ADDR == pwmc_pkg::ADDR_VAL[n] && !tc_w[n]
            |=> O_SFR_RDATA == $past(pend[n]))
            else $error("compare read wrong");
        a_flag_on_roll: assert property (roll[n] |=> q.con[n / 2][nib_lsb(n) + pwmc_pkg::CON_FLAG])
            else $error("rollover flag not set");
        a_pin_override: assert property (oe_w[n] && dc_w[n] |=> O_PWM[n] && O_PWM_OE[n])
            else $error("override not on pin");
        a_pin_gated: assert property (!oe_w[n] |=> !O_PWM[n] && !O_PWM_OE[n])
            else $error("pin driven without enable");
        a_src_div64: assert property (
            !sel_w[n][2] && sel_w[n][1:0] == 2'h3 |-> src_tick[n] == (q.pre == 6'h3f))
            else $error("divide by 64 tap wrong");
        // Same-cycle form, so a select rewrite right after a tick cannot trip it
        a_src_div4: assert property (
            !sel_w[n][2] && sel_w[n][1:0] == 2'h1 |-> src_tick[n] == (q.pre[1:0] == 2'h3))
            else $error("divide by 4 tap wrong");
    end

    c_ext_clock: cover property (sel_w[2][2] && en_w[2] && src_tick[2]);
    c_override: cover property (O_PWM[1] && dc_w[1]);
    c_flag_read: cover property (roll[2] ##[1:20] I_SFR_RD && I_SFR_ADDR == pwmc_pkg::ADDR_CON23);

endmodule

// ### tb/pwmc_pins.sv
`timescale 1ns/1ns
// --------
// Port pins and external clock sources
// --------
module pwmc_pins #(parameter int HALF = 5) (
    // Clock
    input wire logic i_clk,
    // Channel drive
    input wire logic [3:0] i_pwm,
    input wire logic [3:0] i_oe,
    // Pin levels and clock sources
    output logic [3:0] o_pin,
    output logic o_ext_even,
    output logic o_ext_odd
);
    int cnt = 0;
    // Undriven pin goes to its weak pull-up
    assign o_pin = (i_oe & i_pwm) | ~i_oe;
    // Free-running sources; odd pin at half the even rate so a swap shows
    always @(posedge i_clk) begin
        #1;
        cnt = cnt + 1;
        if (cnt % HALF == 0) o_ext_even = ~o_ext_even;
        if (cnt % (2 * HALF) == 0) o_ext_odd = ~o_ext_odd;
    end
    initial begin
        o_ext_even = 1'b1;
        o_ext_odd = 1'b1;
    end
endmodule

// ### tb/pwmc_top_tb.sv
`timescale 1ns/1ns
module pwmc_top_tb;
    // --------
    // Signals
    // --------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdata;
    logic hit;
    logic ev;
    logic od;
    logic [3:0] pwm;
    logic [3:0] oe;
    logic [3:0] pin;
    logic [7:0] d0;
    logic [7:0] d1;
    logic h;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int tick [4];
    int cmp [4] = '{0, 0, 0, 0};
    always #50 clk = ~clk;
    pwmc_top dut (.I_CLOCK(clk), .I_NRST(nrst), .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wd),
        .O_SFR_RDATA(rdata), .O_SFR_HIT(hit), .I_EXT_CLOCK_PIN_EVEN(ev), .I_EXT_CLOCK_PIN_ODD(od), .O_PWM(pwm),
        .O_PWM_OE(oe));
    pwmc_pins pins (.i_clk(clk), .i_pwm(pwm), .i_oe(oe), .o_pin(pin), .o_ext_even(ev), .o_ext_odd(od));
    // --------
    // Checks and bus cycles
    // --------
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_n(input string s, input int e, input int g);
        total_checks++;
        if (g != e) begin
            fails++;
            $display("BAD %s expected %0d seen %0d", s, e, g);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wd = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask
    task automatic rd8(input logic [7:0] a);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        d1 = rdata;
        h = hit;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic eh);
        rd8(a);
        chk($sformatf("reg %h", a), e, d1);
        chk($sformatf("hit %h", a), {7'h00, eh}, {7'h00, h});
    endtask
    function automatic logic [7:0] conb(input int tc, input int en, input int dc);
        int n;
        n = (dc << pwmc_pkg::CON_DC) | (en << pwmc_pkg::CON_OE) | (tc << pwmc_pkg::CON_TC);
        return 8'((n << pwmc_pkg::HI_NIB_LSB) | n);
    endfunction
    task automatic setcon(input int tc, input int en, input int dc);
        wr8(pwmc_pkg::ADDR_CON01, conb(tc, en, dc));
        wr8(pwmc_pkg::ADDR_CON23, conb(tc, en, dc));
    endtask
    function automatic int csn(input int s, input int en);
        return (s << pwmc_pkg::CS_SEL_LSB) | (en << pwmc_pkg::CS_EN);
    endfunction
    task automatic setcs(input int s [4], input int en);
        wr8(pwmc_pkg::ADDR_CS01, 8'((csn(s[0], en) << pwmc_pkg::HI_NIB_LSB) | csn(s[1], en)));
        wr8(pwmc_pkg::ADDR_CS23, 8'((csn(s[2], en) << pwmc_pkg::HI_NIB_LSB) | csn(s[3], en)));
    endtask
    // --------
    // Pin timing against the model's tick lengths
    // --------
    task automatic waitl(input int c, input logic l, input int b, output int n);
        n = 0;
        while (pin[c] !== l && n < b) begin
            @(posedge clk);
            #2;
            n++;
        end
    endtask
    // First rise comes only after the new compare is active, so it is safe to time from
    task automatic meas(input int c);
        int b;
        int n;
        int hi;
        int lo;
        b = 1024 * tick[c];
        waitl(c, 1'b0, b, n);
        waitl(c, 1'b1, b, n);
        waitl(c, 1'b0, b, hi);
        waitl(c, 1'b1, b, lo);
        chk_n($sformatf("high time %0d", c), cmp[c] * tick[c], hi);
        chk_n($sformatf("period %0d", c), 256 * tick[c], hi + lo);
    endtask
    task automatic round(input int s [4], input int dv [4], input int cv [4], input bit live);
        setcs(s, 0);
        setcon(1, 1, 0);
        for (int c = 0; c < 4; c++) begin
            d0 = 8'($urandom_range(255));
            wr8(pwmc_pkg::ADDR_VAL[c], d0);
            rdc(pwmc_pkg::ADDR_VAL[c], d0, 1'b1);
            wr8(pwmc_pkg::ADDR_VAL[c], 8'h00);
        end
        setcon(0, 1, 0);
        for (int c = 0; c < 4; c++) begin
            rdc(pwmc_pkg::ADDR_VAL[c], 8'(cmp[c]), 1'b1);
            cmp[c] = cv[c];
            tick[c] = (s[c] >= 4 ? 10 * (1 + c % 2) : 1 << (2 * s[c])) * (dv[c] + 1);
            wr8(pwmc_pkg::ADDR_FG[c], 8'(dv[c]));
            wr8(pwmc_pkg::ADDR_VAL[c], 8'(cv[c]));
            rdc(pwmc_pkg::ADDR_VAL[c], 8'(cv[c]), 1'b1);
            rdc(pwmc_pkg::ADDR_FG[c], 8'(dv[c]), 1'b1);
        end
        setcs(s, 1);
        fork
            meas(0);
            meas(1);
            meas(2);
            meas(3);
            if (live) begin
                wr8(pwmc_pkg::ADDR_CON01, 8'(conb(0, 1, 0) | (1 << (pwmc_pkg::CON_TC + pwmc_pkg::HI_NIB_LSB))));
                rd8(pwmc_pkg::ADDR_VAL[0]);
                d0 = d1;
                repeat (8) @(posedge clk);
                rd8(pwmc_pkg::ADDR_VAL[0]);
                d0 = d1 - d0;
                chk("timer step", 8'h01, 8'(d0 inside {8'h03, 8'h04}));
                rdc(pwmc_pkg::ADDR_FG[0], 8'(dv[0]), 1'b1);
            end
        join
        setcs(s, 0);
    endtask
    // --------
    // Timeout and main sequence
    // --------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        void'($urandom(8));
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        for (int c = 0; c < 4; c++) begin
            rdc(pwmc_pkg::ADDR_FG[c], 8'h00, 1'b1);
            rdc(pwmc_pkg::ADDR_VAL[c], 8'h00, 1'b1);
        end
        rdc(pwmc_pkg::ADDR_CS01, 8'h00, 1'b1);
        rdc(pwmc_pkg::ADDR_CON23, 8'h00, 1'b1);
        rdc(8'hd8, 8'h00, 1'b0);
        $display("test reset values done");
        round('{0, 1, 2, 4}, '{2, 1, 0, 0}, '{$urandom_range(254, 1), $urandom_range(254, 1),
            $urandom_range(254, 1), $urandom_range(254, 1)}, 1'b1);
        $display("test round one done");
        round('{3, 5, 6, 0}, '{0, 1, 0, 0}, '{$urandom_range(254, 1), $urandom_range(254, 1), 1, 255}, 1'b0);
        $display("test round two done");
        d0 = 8'((1 << (pwmc_pkg::CON_FLAG + pwmc_pkg::HI_NIB_LSB)) | (1 << pwmc_pkg::CON_FLAG));
        rdc(pwmc_pkg::ADDR_CON01, conb(0, 1, 0) | d0, 1'b1);
        rdc(pwmc_pkg::ADDR_CON23, conb(0, 1, 0) | d0, 1'b1);
        setcon(0, 1, 0);
        rdc(pwmc_pkg::ADDR_CON01, conb(0, 1, 0), 1'b1);
        setcon(1, 1, 0);
        for (int c = 0; c < 4; c++) begin
            rd8(pwmc_pkg::ADDR_VAL[c]);
            d0 = d1;
            repeat (20) @(posedge clk);
            rdc(pwmc_pkg::ADDR_VAL[c], d0, 1'b1);
        end
        $display("test flags and freeze done");
        setcon(0, 1, 1);
        repeat (3) @(posedge clk);
        chk("pins", 8'h0f, {4'h0, pin});
        chk("drive enable", 8'h0f, {4'h0, oe});
        setcon(0, 0, 1);
        repeat (3) @(posedge clk);
        chk("pwm", 8'h00, {4'h0, pwm});
        chk("drive enable", 8'h00, {4'h0, oe});
        $display("test override done");
        #1;
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        for (int c = 0; c < 4; c++) begin
            rdc(pwmc_pkg::ADDR_FG[c], 8'h00, 1'b1);
            rdc(pwmc_pkg::ADDR_VAL[c], 8'h00, 1'b1);
        end
        rdc(pwmc_pkg::ADDR_CON01, 8'h00, 1'b1);
        rdc(pwmc_pkg::ADDR_CS23, 8'h00, 1'b1);
        chk("drive enable after reset", 8'h00, {4'h0, oe});
        $display("test mid-run reset done");
        final_report();
    end
endmodule
